// file: pkg/sic_pkg.sv
// sic_pkg: constants shared by the instruction cache and its line buffer.
// assumes a 32-bit byte address and 32-bit instruction words.
package sic_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NUM_WAYS = 4;
    localparam int WAY_W = 2;
    localparam int LINE_WORDS = 8;
    localparam int WORD_LSB = 2;
    localparam int WORD_W = 3;
    localparam int INDEX_LSB = 5;
    // capacity as log2 of bytes; 12 is 4KB, 20 is 1MB, 0 means no cache
    localparam int CACHE_LOG2_DEFAULT = 12;
    localparam int WAY_BYTES_LOG2_OFS = 2;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_PTR_W = 2;
    localparam int FIFO_CNT_W = 3;
    localparam int LFSR_W = 4;
    localparam logic [3:0] LFSR_RESET = 4'h1;
    localparam logic [1:0] LOCK_BASE_RESET = 2'h0;
    localparam logic [2:0] WORD_ZERO = 3'h0;
    localparam logic [2:0] WORD_LAST = 3'h7;
    typedef enum logic [1:0] {
        SIC_IDLE = 2'b00,
        SIC_FILL = 2'b01,
        SIC_SINGLE = 2'b10,
        SIC_FLUSH = 2'b11
    } sic_state_type;
endpackage : sic_pkg

// file: src/sic_icache.sv
// sic_icache: four-way instruction cache with linefill FIFO and flush walker.
// assumes one clock, a synchronous core fetch port and a valid/ready memory port.
`timescale 1ns/100ps

module sic_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PW:0] count, next_count;
    logic push, pop;

    // handshakes and pointer arithmetic
    always_comb begin
        in_ready_o = (count != DEPTH[PW:0]);
        out_valid_o = (count != '0);
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = (PW+1)'(count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
        out_data_o = mem[rd_ptr];
    end

    // pointer registers and storage
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule : sic_fifo

// How it works
// - four ways, each with tag and data store, eight-word lines.
// - capacity is a build parameter, 0KB or 4KB to 1MB by powers of two.
// - a read hit answers in one clock cycle.
// - first nonsequential access compares all four tags in parallel.
// - matching way returns data; a total miss goes to external memory.
// - only cachable read misses allocate, into one of four ways.
// - a segment counter picks the victim, pseudo-random or round-robin.
// - lockdown limits the ways the counter may choose.
// - whole flush clears every line, locked ones included.
// - address splits into byte, word, index and tag fields.
// - index starts at bit 5, widens with capacity; tag is the rest.
// - each tag has a valid bit; only valid lines hit; reset clears all.
// - enable bit 12 only acts when the protection unit is enabled.
// - a hit returns data only when the cachable attribute is set.
// - cachable miss fetches eight words starting at word 0.
// - non-cachable miss does one single-word fetch, cache untouched.
// - disabled cache: no lookups, no fills, single external fetches.
// - reset invalidates the whole instruction cache.
// - software flush command clears every line.
// - the core never writes cache contents; only linefills do.
module sic_icache #(
    parameter int CACHE_LOG2 = sic_pkg::CACHE_LOG2_DEFAULT
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // control bits from the system control coprocessor
    input wire logic ctrl_word_i_unused_i,
    input wire logic [31:0] system_control_coprocessor_i,
    input wire logic protection_enable_i,
    input wire logic replace_round_robin_i,
    input wire logic [1:0] lock_base_i,
    input wire logic flush_all_i,
    // core fetch port
    input wire logic fetch_req_i,
    input wire logic fetch_seq_i,
    input wire logic [31:0] fetch_addr_i,
    input wire logic cachable_instruction_attr_i,
    output logic fetch_ready_o,
    output logic fetch_valid_o,
    output logic [31:0] fetch_data_o,
    // status
    output logic cache_active_o,
    output logic flush_busy_o,
    // external memory port
    output logic mem_req_o,
    output logic [31:0] mem_addr_o,
    output logic mem_burst_o,
    input wire logic mem_ack_i,
    input wire logic mem_rvalid_i,
    output logic mem_rready_o,
    input wire logic [31:0] mem_rdata_i
);
    // geometry: way size is a quarter of capacity
    localparam int SIZE_LOG2 = (CACHE_LOG2 < 12) ? 12 : CACHE_LOG2;
    localparam int IDX_W = SIZE_LOG2 - sic_pkg::INDEX_LSB - sic_pkg::WAY_BYTES_LOG2_OFS;
    localparam int TAG_LSB = sic_pkg::INDEX_LSB + IDX_W;
    localparam int TAG_W = sic_pkg::ADDR_W - TAG_LSB;
    localparam int SETS = 1 << IDX_W;
    localparam bit PRESENT = (CACHE_LOG2 != 0);

    // storage: tag, valid and data arrays per way
    logic [TAG_W-1:0] tag_mem [sic_pkg::NUM_WAYS][SETS];
    logic [31:0] data_mem [sic_pkg::NUM_WAYS][SETS*sic_pkg::LINE_WORDS];
    logic [SETS-1:0] valid [sic_pkg::NUM_WAYS];

    sic_pkg::sic_state_type state, next_state;
    logic [31:0] req_addr, next_req_addr;
    logic [2:0] fill_word, next_fill_word;
    logic [1:0] victim, next_victim;
    logic [sic_pkg::LFSR_W-1:0] lfsr, next_lfsr;
    logic [IDX_W-1:0] flush_idx, next_flush_idx;
    logic last_valid, next_last_valid;
    logic [1:0] last_way, next_last_way;
    logic [31-sic_pkg::INDEX_LSB:0] last_line, next_last_line;
    logic fetch_valid, next_fetch_valid;
    logic [31:0] fetch_data, next_fetch_data;
    logic mem_req, next_mem_req;
    logic mem_burst, next_mem_burst;
    logic enabled;
    logic [3:0] way_hit;
    logic hit, seq_hit, any_hit;
    logic [1:0] hit_way, use_way;
    logic [IDX_W-1:0] idx;
    logic [TAG_W-1:0] tag;
    logic fifo_valid, fifo_ready, fill_pop;
    logic [31:0] fifo_data;
    logic fill_write;
    logic [IDX_W:0] flush_run, next_flush_run;

    function automatic logic [IDX_W-1:0] idx_of(input logic [31:0] a);
        idx_of = a[TAG_LSB-1:sic_pkg::INDEX_LSB];
    endfunction : idx_of

    function automatic logic [IDX_W+2:0] word_slot(input logic [31:0] a, input logic [2:0] w);
        word_slot = {idx_of(a), w};
    endfunction : word_slot

    // enable requires the protection unit; zero-size never enables
    assign enabled = PRESENT && system_control_coprocessor_i[12] && protection_enable_i;
    assign idx = idx_of(fetch_addr_i);
    assign tag = fetch_addr_i[31:TAG_LSB];

    // parallel tag compare on valid lines only
    always_comb begin
        for (int w = 0; w < sic_pkg::NUM_WAYS; w++) begin
            way_hit[w] = valid[w][idx] && (tag_mem[w][idx] == tag);
        end
        hit = |way_hit;
        hit_way = way_hit[3] ? 2'h3 : way_hit[2] ? 2'h2 : way_hit[1] ? 2'h1 : 2'h0;
    end

    // sequential access in same line reuses last way
    assign seq_hit = fetch_seq_i && last_valid && (last_line == fetch_addr_i[31:sic_pkg::INDEX_LSB]);
    assign any_hit = enabled && cachable_instruction_attr_i && (seq_hit || hit);
    assign use_way = seq_hit ? last_way : hit_way;
    assign fill_pop = (state == sic_pkg::SIC_FILL) || (state == sic_pkg::SIC_SINGLE);
    assign fill_write = (state == sic_pkg::SIC_FILL) && fifo_valid;

    // memory reads pass through a small FIFO before reaching the arrays
    sic_fifo #(
        .WIDTH(sic_pkg::DATA_W),
        .DEPTH(sic_pkg::FIFO_DEPTH)
    ) u_fill_fifo (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(mem_rvalid_i),
        .in_ready_o(fifo_ready),
        .in_data_i(mem_rdata_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fill_pop),
        .out_data_o(fifo_data)
    );

    // next-state logic for the controller
    always_comb begin
        next_state = state;
        next_req_addr = req_addr;
        next_fill_word = fill_word;
        next_victim = victim;
        next_flush_idx = flush_idx;
        next_last_valid = last_valid;
        next_last_way = last_way;
        next_last_line = last_line;
        next_fetch_valid = 1'b0;
        next_fetch_data = fetch_data;
        next_mem_req = mem_req && !mem_ack_i;
        next_mem_burst = mem_burst;
        next_flush_run = (state == sic_pkg::SIC_FLUSH) ? (IDX_W+1)'(flush_run + 1'b1) : '0; // flush walk length
        // segment counter: lfsr or round-robin step
        next_lfsr = {lfsr[2:0], lfsr[3] ^ lfsr[2]};
        unique case (state)
            sic_pkg::SIC_IDLE: begin
                if (flush_all_i) begin
                    next_state = sic_pkg::SIC_FLUSH;
                    next_flush_idx = '0;
                    next_last_valid = 1'b0;
                end else if (fetch_req_i && any_hit) begin
                    next_fetch_valid = 1'b1;
                    next_fetch_data = data_mem[use_way][word_slot(fetch_addr_i, fetch_addr_i[4:2])];
                    next_last_valid = 1'b1;
                    next_last_way = use_way;
                    next_last_line = fetch_addr_i[31:sic_pkg::INDEX_LSB];
                end else if (fetch_req_i) begin
                    // miss handling; reads only, no write path or dirty state
                    next_req_addr = fetch_addr_i;
                    next_mem_req = 1'b1;
                    next_fill_word = sic_pkg::WORD_ZERO;
                    if (enabled && cachable_instruction_attr_i) begin
                        next_state = sic_pkg::SIC_FILL;
                        next_mem_burst = 1'b1;
                        if (replace_round_robin_i) begin
                            next_victim = (victim == 2'h3) ? lock_base_i : 2'(victim + 1'b1);
                        end else begin
                            next_victim = (lfsr[1:0] < lock_base_i) ? lock_base_i : lfsr[1:0];
                        end
                        if (next_victim < lock_base_i) begin
                            next_victim = lock_base_i;
                        end
                    end else begin
                        next_state = sic_pkg::SIC_SINGLE;
                        next_mem_burst = 1'b0;
                    end
                end
            end
            sic_pkg::SIC_FILL: begin
                if (fifo_valid) begin
                    next_fill_word = 3'(fill_word + 1'b1);
                    if (fill_word == next_req_addr[4:2]) begin
                        next_fetch_valid = 1'b1;
                        next_fetch_data = fifo_data;
                    end
                    if (fill_word == sic_pkg::WORD_LAST) begin
                        next_state = sic_pkg::SIC_IDLE;
                        next_last_valid = 1'b1;
                        next_last_way = victim;
                        next_last_line = req_addr[31:sic_pkg::INDEX_LSB];
                    end
                end
            end
            sic_pkg::SIC_SINGLE: begin
                if (fifo_valid) begin
                    next_fetch_valid = 1'b1;
                    next_fetch_data = fifo_data;
                    next_state = sic_pkg::SIC_IDLE;
                end
            end
            sic_pkg::SIC_FLUSH: begin
                next_flush_idx = IDX_W'(flush_idx + 1'b1);
                if (flush_idx == '1) begin
                    next_state = sic_pkg::SIC_IDLE;
                end
            end
        endcase
    end

    // controller registers; reset starts a full flush walk
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            state <= sic_pkg::SIC_FLUSH;
            req_addr <= '0;
            fill_word <= sic_pkg::WORD_ZERO;
            victim <= sic_pkg::LOCK_BASE_RESET;
            lfsr <= sic_pkg::LFSR_RESET;
            flush_idx <= '0;
            last_valid <= 1'b0;
            last_way <= '0;
            last_line <= '0;
            fetch_valid <= 1'b0;
            fetch_data <= '0;
            mem_req <= 1'b0;
            mem_burst <= 1'b0;
            flush_run <= '0;
        end else begin
            state <= next_state;
            req_addr <= next_req_addr;
            fill_word <= next_fill_word;
            victim <= next_victim;
            lfsr <= next_lfsr;
            flush_idx <= next_flush_idx;
            last_valid <= next_last_valid;
            last_way <= next_last_way;
            last_line <= next_last_line;
            fetch_valid <= next_fetch_valid;
            fetch_data <= next_fetch_data;
            mem_req <= next_mem_req;
            mem_burst <= next_mem_burst;
            flush_run <= next_flush_run;
        end
    end

    // array writes: flush clears valid, only fills write data
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || state == sic_pkg::SIC_FLUSH) begin
            for (int w = 0; w < sic_pkg::NUM_WAYS; w++) begin
                valid[w][reset_n_i ? flush_idx : '0] <= 1'b0;
            end
        end else if (fill_write) begin
            data_mem[victim][word_slot(req_addr, fill_word)] <= fifo_data;
            if (fill_word == sic_pkg::WORD_ZERO) begin
                valid[victim][idx_of(req_addr)] <= 1'b0;
                tag_mem[victim][idx_of(req_addr)] <= req_addr[31:TAG_LSB];
            end
            if (fill_word == sic_pkg::WORD_LAST) begin
                valid[victim][idx_of(req_addr)] <= 1'b1;
            end
        end
    end

    // outputs
    assign fetch_ready_o = (state == sic_pkg::SIC_IDLE) && !flush_all_i;
    assign fetch_valid_o = fetch_valid;
    assign fetch_data_o = fetch_data;
    assign cache_active_o = enabled;
    assign flush_busy_o = (state == sic_pkg::SIC_FLUSH);
    assign mem_req_o = mem_req;
    assign mem_addr_o = mem_burst ? {req_addr[31:sic_pkg::INDEX_LSB], 5'h00} : req_addr;
    assign mem_burst_o = mem_burst;
    assign mem_rready_o = fifo_ready;

    // assertions
    property p_hit_one_cycle;
        @(posedge clock_i) disable iff (!reset_n_i)
        (state == sic_pkg::SIC_IDLE && fetch_req_i && !flush_all_i && any_hit) |=> fetch_valid_o;
    endproperty
    a_hit_one_cycle: assert property (p_hit_one_cycle) else $error("hit not answered next cycle");

    property p_disabled_single;
        @(posedge clock_i) disable iff (!reset_n_i)
        (state == sic_pkg::SIC_IDLE && fetch_req_i && !flush_all_i && !enabled) |=> !mem_burst_o;
    endproperty
    a_disabled_single: assert property (p_disabled_single) else $error("disabled cache issued a burst");

    property p_noncache_single;
        @(posedge clock_i) disable iff (!reset_n_i)
        (state == sic_pkg::SIC_IDLE && fetch_req_i && !flush_all_i && !cachable_instruction_attr_i)
            |=> state == sic_pkg::SIC_SINGLE;
    endproperty
    a_noncache_single: assert property (p_noncache_single) else $error("non-cachable miss filled");

    property p_fill_aligned;
        @(posedge clock_i) disable iff (!reset_n_i)
        mem_burst_o |-> mem_addr_o[4:0] == 5'h00;
    endproperty
    a_fill_aligned: assert property (p_fill_aligned) else $error("linefill not line aligned");

    property p_victim_unlocked;
        @(posedge clock_i) disable iff (!reset_n_i)
        $rose(state == sic_pkg::SIC_FILL) |-> victim >= lock_base_i;
    endproperty
    a_victim_unlocked: assert property (p_victim_unlocked) else $error("locked way chosen");

    property p_flush_len;
        @(posedge clock_i) disable iff (!reset_n_i)
        ((state == sic_pkg::SIC_IDLE && flush_all_i) |=> flush_busy_o)
            and (flush_busy_o |-> flush_run < (IDX_W+1)'(SETS));
    endproperty
    a_flush_len: assert property (p_flush_len) else $error("flush did not start or overran");

    property p_enable_gated;
        @(posedge clock_i) disable iff (!reset_n_i)
        !protection_enable_i |-> !cache_active_o;
    endproperty
    a_enable_gated: assert property (p_enable_gated) else $error("enabled without protection");

    sequence s_fill_end;
        state == sic_pkg::SIC_FILL && fifo_valid && fill_word == sic_pkg::WORD_LAST;
    endsequence
    property p_fill_valid;
        @(posedge clock_i) disable iff (!reset_n_i)
        s_fill_end |=> valid[last_way][idx_of(req_addr)];
    endproperty
    a_fill_valid: assert property (p_fill_valid) else $error("filled line not valid");
endmodule : sic_icache

// file: verif/set_assoc_instruction_cache_tb_top.sv
// set_assoc_instruction_cache_tb_top: self-checking bench for the instruction cache.
// assumes sic_mem_model on the memory port and a 4KB build of the cache.
`timescale 1ns/100ps
module set_assoc_instruction_cache_tb_top;
    localparam int CL = 12;
    localparam int SETS = 2 ** (CL - 7);
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [31:0] system_control_coprocessor_i = 32'h0;
    logic protection_enable_i = 1'b0;
    logic replace_round_robin_i = 1'b1;
    logic [1:0] lock_base_i = 2'h0;
    logic flush_all_i = 1'b0;
    logic fetch_req_i = 1'b0;
    logic fetch_seq_i = 1'b0;
    logic [31:0] fetch_addr_i = 32'h0;
    logic cachable_instruction_attr_i = 1'b1;
    logic fetch_ready_o, fetch_valid_o, cache_active_o, flush_busy_o;
    logic [31:0] fetch_data_o, mem_addr_o, mem_rdata_i, last_addr;
    logic mem_req_o, mem_burst_o, mem_ack_i, mem_rvalid_i, mem_rready_o, last_burst;
    logic mem_stall = 1'b0;
    logic [31:0] seed = 32'd5657;
    logic [31:0] st;
    logic [31:0] r;
    int num_errors = 0;
    int n_tests = 0;
    int n_mem = 0;

    always #25 clock_i = ~clock_i;

    sic_icache #(.CACHE_LOG2(CL)) dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .ctrl_word_i_unused_i(1'b0),
        .system_control_coprocessor_i(system_control_coprocessor_i), .protection_enable_i(protection_enable_i),
        .replace_round_robin_i(replace_round_robin_i), .lock_base_i(lock_base_i), .flush_all_i(flush_all_i),
        .fetch_req_i(fetch_req_i), .fetch_seq_i(fetch_seq_i), .fetch_addr_i(fetch_addr_i),
        .cachable_instruction_attr_i(cachable_instruction_attr_i), .fetch_ready_o(fetch_ready_o),
        .fetch_valid_o(fetch_valid_o), .fetch_data_o(fetch_data_o), .cache_active_o(cache_active_o),
        .flush_busy_o(flush_busy_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_burst_o(mem_burst_o),
        .mem_ack_i(mem_ack_i), .mem_rvalid_i(mem_rvalid_i), .mem_rready_o(mem_rready_o), .mem_rdata_i(mem_rdata_i));

    sic_mem_model mem_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .stall_i(mem_stall), .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .mem_burst_i(mem_burst_o), .mem_ack_o(mem_ack_i), .mem_rvalid_o(mem_rvalid_i),
        .mem_rready_i(mem_rready_o), .mem_rdata_o(mem_rdata_i));

    // xorshift source for all random stimulus
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // expected instruction word at an address
    function automatic logic [31:0] exp_word(input logic [31:0] a);
        return {a[31:2], 2'b00} ^ 32'hC3A5_0F69;
    endfunction : exp_word

    // memory stalls about one cycle in four
    always @(posedge clock_i) begin
        st = rnd();
        mem_stall <= st[0] & st[1];
    end

    // note every memory request at the edge where it is accepted
    always @(posedge clock_i) begin
        if (reset_n_i && mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
            n_mem++;
            last_addr <= mem_addr_o;
            last_burst <= mem_burst_o;
        end
    end

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    // one fetch; exp_req below zero skips the memory traffic checks
    task automatic run(input logic [31:0] a, input logic seq, input logic attr, input int exp_req, input logic burst);
        int n;
        int m0;
        n = 0;
        m0 = n_mem;
        @(posedge clock_i);
        fetch_req_i <= 1'b1;
        fetch_seq_i <= seq;
        fetch_addr_i <= a;
        cachable_instruction_attr_i <= attr;
        do begin
            @(negedge clock_i);
            n++;
        end while (fetch_ready_o !== 1'b1 && n < 3000);
        @(posedge clock_i);
        fetch_req_i <= 1'b0;
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (fetch_valid_o !== 1'b1 && n < 300);
        chk_bit("fetch valid", 1'b1, fetch_valid_o);
        chk_word("fetch data", exp_word(a), fetch_data_o);
        @(negedge clock_i);
        chk_bit("valid pulse", 1'b0, fetch_valid_o);
        if (exp_req == 0) chk_word("hit latency", 32'h1, 32'(n));
        if (exp_req >= 0) chk_word("mem requests", 32'(exp_req), 32'(n_mem - m0));
        if (exp_req == 1) begin
            chk_bit("burst", burst, last_burst);
            chk_word("mem address", burst ? {a[31:5], 5'h00} : a, last_addr);
        end
    endtask : run

    // whole-cache flush, timing the walk
    task automatic flush_cache();
        int n;
        n = 0;
        do @(negedge clock_i); while (fetch_ready_o !== 1'b1);
        @(posedge clock_i);
        flush_all_i <= 1'b1;
        @(posedge clock_i);
        flush_all_i <= 1'b0;
        @(negedge clock_i);
        while (flush_busy_o === 1'b1 && n < 5000) begin
            n++;
            @(negedge clock_i);
        end
        chk_word("flush cycles", 32'(SETS), 32'(n));
    endtask : flush_cache

    task automatic end_sim();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clock_i);
        num_errors++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b1;
        system_control_coprocessor_i <= rnd() | 32'h0000_1000;
        protection_enable_i <= 1'b1;
        run(32'h0000_2468, 1'b0, 1'b1, 1, 1'b1);
        run(32'h0000_246C, 1'b1, 1'b1, 0, 1'b0);
        run(32'h0000_2460, 1'b0, 1'b1, 0, 1'b0);
        run(32'h0000_2468, 1'b0, 1'b0, 1, 1'b0);
        run(32'h0000_3104, 1'b0, 1'b0, 1, 1'b0);
        run(32'h0000_3104, 1'b0, 1'b1, 1, 1'b1);
        run(32'h0000_3108, 1'b0, 1'b1, 0, 1'b0);
        protection_enable_i <= 1'b0;
        run(32'h0000_3108, 1'b0, 1'b1, 1, 1'b0);
        chk_bit("cache active", 1'b0, cache_active_o);
        protection_enable_i <= 1'b1;
        system_control_coprocessor_i[12] <= 1'b0;
        run(32'h0000_3108, 1'b0, 1'b1, 1, 1'b0);
        chk_bit("cache active", 1'b0, cache_active_o);
        system_control_coprocessor_i[12] <= 1'b1;
        run(32'h0000_3108, 1'b0, 1'b1, 0, 1'b0);
        chk_bit("cache active", 1'b1, cache_active_o);
        flush_cache();
        run(32'h0000_3108, 1'b0, 1'b1, 1, 1'b1);
        // only way 3 may be replaced, so the second tag evicts the first
        lock_base_i <= 2'h3;
        run(32'h0000_0040, 1'b0, 1'b1, 1, 1'b1);
        run(32'h0000_0440, 1'b0, 1'b1, 1, 1'b1);
        run(32'h0000_0040, 1'b0, 1'b1, 1, 1'b1);
        // four tags of one set all stay resident with round robin
        flush_cache();
        lock_base_i <= 2'h0;
        for (int t = 0; t < 4; t++) run(32'h0000_0040 | (t << 10), 1'b0, 1'b1, 1, 1'b1);
        for (int t = 0; t < 4; t++) run(32'h0000_0044 | (t << 10), 1'b0, 1'b1, 0, 1'b0);
        // random fetches over a few sets and tags with changing victim policy
        for (int i = 0; i < 150; i++) begin
            r = rnd();
            @(posedge clock_i);
            lock_base_i <= r[31:30];
            replace_round_robin_i <= r[29];
            run(r & 32'h0000_1C3C, 1'b0, r[8] | r[9], -1, 1'b0);
        end
        end_sim();
    end
endmodule : set_assoc_instruction_cache_tb_top

// file: verif/sic_mem_model.sv
// sic_mem_model: external memory answering the cache's line fills and single reads.
// assumes the cache holds its request until acknowledged and takes beats on rvalid and rready.
`timescale 1ns/100ps
module sic_mem_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // slow-down control from the bench
    input wire logic stall_i,
    // request side
    input wire logic mem_req_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic mem_burst_i,
    output logic mem_ack_o,
    // read data stream
    output logic mem_rvalid_o,
    input wire logic mem_rready_i,
    output logic [31:0] mem_rdata_o
);
    logic busy;
    logic [31:0] base;
    logic [3:0] beats;
    logic [3:0] cnt;

    // contents are a fixed scramble of the word address
    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return {a[31:2], 2'b00} ^ 32'hC3A5_0F69;
    endfunction : mem_word

    // acknowledge one request, then stream its beats in address order
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            mem_ack_o <= 1'b0;
            mem_rvalid_o <= 1'b0;
            busy <= 1'b0;
            cnt <= 4'h0;
            mem_rdata_o <= 32'h0;
        end else begin
            mem_ack_o <= 1'b0;
            if (!busy && mem_req_i && !mem_ack_o && !stall_i) begin
                mem_ack_o <= 1'b1;
                busy <= 1'b1;
                cnt <= 4'h0;
                base <= mem_burst_i ? {mem_addr_i[31:5], 5'h00} : mem_addr_i;
                beats <= mem_burst_i ? 4'h8 : 4'h1;
            end else if (busy && mem_rvalid_o && mem_rready_i) begin
                cnt <= cnt + 4'h1;
                mem_rvalid_o <= 1'b0;
                mem_rdata_o <= ~mem_rdata_o; // released line shows no stale word
                busy <= (cnt + 4'h1) != beats;
                if ((cnt + 4'h1) != beats && !stall_i) begin
                    mem_rvalid_o <= 1'b1;
                    mem_rdata_o <= mem_word(base + {26'h0, cnt + 4'h1, 2'b00});
                end
            end else if (busy && !mem_rvalid_o && !mem_ack_o && !stall_i) begin
                mem_rvalid_o <= 1'b1;
                mem_rdata_o <= mem_word(base + {26'h0, cnt, 2'b00});
            end
        end
    end
endmodule : sic_mem_model
